// ### hw/ctwp_top.sv
// cascaded timer, watchdog, power-down control and receive error flags
// =====================================================
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ctwp_regs.svh"

module ctwp_top
    import ctwp_pkg::*;
#(
    parameter int TW = 16
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins and receiver events
    input wire ctwp_pins_t pins,
    input wire ctwp_rx_t rx,
    input wire logic core_irq,
    // towards the core
    output logic core_reset,
    output logic cpu_halt,
    output logic osc_stop,
    output logic wake_resume_next,
    output logic wake_service,
    output logic low_timer_overflow_flag,
    output logic high_timer_overflow_flag
);

    // =====================================================
    // state
    logic [7:0] io_control_register;
    logic [7:0] io_next;
    logic [7:0] power_control_register;
    logic [7:0] pc_next;
    logic [7:0] timer_mode_register;
    logic [7:0] tm_next;
    logic [7:0] tcon_reg;
    logic [7:0] tcon_next;
    logic [TW-1:0] tlow_reg;
    logic [TW-1:0] tlow_next;
    logic [TW-1:0] thigh_reg;
    logic [TW-1:0] thigh_next;
    logic receive_done_flag;
    logic rxf_next;
    logic [3:0] phase_reg;
    logic samp0_reg;
    logic samp1_reg;
    logic c1_prev_reg;
    logic pend0_reg;
    logic pend1_reg;
    logic wd_arm_reg;
    logic [2:0] wd_cnt_reg;
    logic [2:0] wd_cnt_next;
    logic hw_pd_reg;
    logic rise_seen_reg;
    logic wake_res_reg;
    logic wake_srv_reg;
    logic [31:0] prdata_reg;
    logic err_reg;
    ctwp_pwr_t pwr_reg;
    ctwp_pwr_t pwr_next;
    logic hw_pd_next;
    logic exit_now;

    // =====================================================
    // apb decode
    wire setup = psel & ~penable;
    wire wr_en = psel & penable & pwrite & ~core_reset;
    wire a_io = paddr == `CTWP_IO_CONTROL_REGISTER_OFS;
    wire a_pc = paddr == `CTWP_POWER_CONTROL_REGISTER_OFS;
    wire a_tm = paddr == `CTWP_TIMER_MODE_REGISTER_OFS;
    wire a_tc = paddr == `CTWP_TCON_OFS;
    wire a_tl = paddr == `CTWP_TLOW_OFS;
    wire a_th = paddr == `CTWP_THIGH_OFS;
    wire a_se = paddr == `CTWP_SER_OFS;
    wire a_st = paddr == `CTWP_STAT_OFS;
    wire mapped = a_io | a_pc | a_tm | a_tc | a_tl | a_th | a_se | a_st;
    wire [7:0] wb = pwdata[7:0];
    wire [7:0] pc_rd = power_control_register & ~(8'h01 << `CTWP_PC_RSVD);
    wire [7:0] stat_rd = {3'h0, hw_pd_reg, core_reset, pwr_reg};
    wire [31:0] rd_val =
        a_io ? {24'h000000, io_control_register} :
        a_pc ? {24'h000000, pc_rd} :
        a_tm ? {24'h000000, timer_mode_register} :
        a_tc ? {24'h000000, tcon_reg} :
        a_tl ? {{(32-TW){1'b0}}, tlow_reg} :
        a_th ? {{(32-TW){1'b0}}, thigh_reg} :
        a_se ? {31'h00000000, receive_done_flag} :
        a_st ? {24'h000000, stat_rd} : 32'h00000000;

    // answer in the first access cycle; read data was caught at setup
    assign pready = penable;
    assign pslverr = penable & err_reg;
    assign prdata = prdata_reg;

    // =====================================================
    // machine cycle phases
    wire s3p1 = phase_reg == `CTWP_PH_S3P1;
    wire s5p1 = phase_reg == `CTWP_PH_S5P1;
    wire s5p2 = phase_reg == `CTWP_PH_S5P2;
    wire mc_end = phase_reg == `CTWP_PH_LAST;

    // =====================================================
    // count sources
    wire casc = io_control_register[`CTWP_IO_CASC];
    wire wdog = io_control_register[`CTWP_IO_WDOG];
    wire ct0 = timer_mode_register[`CTWP_TM_CT0];
    wire ct1 = timer_mode_register[`CTWP_TM_CT1];
    wire run0 = tcon_reg[`CTWP_TC_TR0];
    wire run1 = tcon_reg[`CTWP_TC_TR1];
    wire pd_on = pwr_reg == PWR_DOWN;
    // internal timing stops with the oscillator in power-down
    wire int_tick = s3p1 & ~pd_on;
    wire ext0 = s5p2 & samp0_reg & ~pins.count_input_zero;
    wire ext1 = s5p2 & samp1_reg & ~pins.count_input_one;
    wire src0 = ct0 ? ext0 : int_tick;
    wire src1 = ct1 ? ext1 : int_tick;
    wire inc_low = casc ? src0 : run0 & src0;
    wire ovf_low = inc_low & (&tlow_reg);
    // otherwise timer 1 follows its own setting
    wire inc_high = casc ? ovf_low : run1 & src1;
    wire ovf_high = inc_high & (&thigh_reg);
    wire tf0_set = s5p1 & pend0_reg;
    wire tf1_set = s5p1 & pend1_reg;
    // with the watchdog bit set, any overflow that sets the high flag
    wire wd_trig = tf1_set & wdog;
    wire wd_start = mc_end & wd_arm_reg;

    // =====================================================
    // power-down wake sources
    wire hw_fall = c1_prev_reg & ~pins.count_input_one;
    wire hw_rise = ~c1_prev_reg & pins.count_input_one;
    wire ext_ct1 = casc ? ct0 : ct1;
    // external interrupts or externally clocked overflow
    wire pwr_irq = ~pins.ext_int0_n | ~pins.ext_int1_n |
        (tcon_reg[`CTWP_TC_TF0] & ct0) |
        (tcon_reg[`CTWP_TC_TF1] & ext_ct1);
    wire idle_irq = core_irq | pwr_irq;
    wire hardware_power_select = power_control_register[`CTWP_PC_HPD];
    wire recover_power_select = power_control_register[`CTWP_PC_RPD];
    wire sw_pd = power_control_register[`CTWP_PC_PD];
    wire rise_got = rise_seen_reg | hw_rise;

    // =====================================================
    // power state machine
    always_comb
    begin
        pwr_next = pwr_reg;
        hw_pd_next = hw_pd_reg;
        exit_now = 1'b0;
        case (pwr_reg)
            PWR_RUN:
            begin
                if (sw_pd)
                    pwr_next = PWR_DOWN;
                else if (hardware_power_select & hw_fall)
                begin
                    pwr_next = PWR_DOWN;
                    hw_pd_next = 1'b1;
                end
                else if (power_control_register[`CTWP_PC_IDL])
                    pwr_next = PWR_IDLE;
            end
            PWR_IDLE:
            begin
                exit_now = idle_irq;
            end
            PWR_DOWN:
            begin
                if (sw_pd & (hw_pd_reg | hardware_power_select))
                    exit_now = rise_got & pwr_irq;
                else if (hw_pd_reg)
                    exit_now = rise_got;
                else
                    exit_now = pwr_irq;
            end
            default:
            begin
                pwr_next = PWR_RUN;
            end
        endcase
        if (exit_now)
        begin
            pwr_next = PWR_RUN;
            hw_pd_next = 1'b0;
        end
    end

    // =====================================================
    // register next values
    always_comb
    begin
        io_next = io_control_register;
        pc_next = power_control_register;
        tm_next = timer_mode_register;
        tcon_next = tcon_reg;
        tlow_next = inc_low ? tlow_reg + 1'b1 : tlow_reg;
        thigh_next = inc_high ? thigh_reg + 1'b1 : thigh_reg;
        rxf_next = receive_done_flag;
        if (wr_en & a_io)
            io_next = wb;
        if (wr_en & a_pc)
            pc_next = wb & ~(8'h01 << `CTWP_PC_RSVD);
        if (wr_en & a_tm)
            tm_next = wb;
        if (wr_en & a_tc)
            tcon_next = wb;
        if (wr_en & a_tl)
            tlow_next = pwdata[TW-1:0];
        if (wr_en & a_th)
            thigh_next = pwdata[TW-1:0];
        if (wr_en & a_se & ~pwdata[0])
            rxf_next = 1'b0;
        // flags set, winning over software clear
        if (tf0_set)
            tcon_next[`CTWP_TC_TF0] = 1'b1;
        if (tf1_set)
            tcon_next[`CTWP_TC_TF1] = 1'b1;
        if (rx.stop_sample)
            rxf_next = 1'b1;
        if (rx.stop_sample & (~rx.stop_level | receive_done_flag))
            io_next[`CTWP_IO_SERIAL_ERROR_FLAG] = 1'b1;
        // leaving a low power mode clears its bits
        if (exit_now)
        begin
            pc_next[`CTWP_PC_PD] = 1'b0;
            pc_next[`CTWP_PC_IDL] = 1'b0;
        end
        if (wd_start)
        begin
            io_next = `CTWP_REG8_RST;
            pc_next = `CTWP_REG8_RST;
            tm_next = `CTWP_REG8_RST;
            tcon_next = `CTWP_REG8_RST;
            tlow_next = '0;
            thigh_next = '0;
            rxf_next = 1'b0;
        end
    end

    // five machine cycles, counted at cycle ends
    always_comb
    begin
        wd_cnt_next = wd_cnt_reg;
        if (wd_start)
            wd_cnt_next = `CTWP_WD_CYCLES;
        else if (mc_end & (wd_cnt_reg != 3'h0))
            wd_cnt_next = wd_cnt_reg - 3'h1;
    end

    // =====================================================
    // registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            io_control_register <= `CTWP_REG8_RST;
            power_control_register <= `CTWP_REG8_RST;
            timer_mode_register <= `CTWP_REG8_RST;
            tcon_reg <= `CTWP_REG8_RST;
            tlow_reg <= '0;
            thigh_reg <= '0;
            receive_done_flag <= 1'b0;
        end
        else
        begin
            io_control_register <= io_next;
            power_control_register <= pc_next;
            timer_mode_register <= tm_next;
            tcon_reg <= tcon_next;
            tlow_reg <= tlow_next;
            thigh_reg <= thigh_next;
            receive_done_flag <= rxf_next;
        end
    end

    // machine cycle phase and pin samples
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            phase_reg <= 4'h0;
            samp0_reg <= 1'b0;
            samp1_reg <= 1'b0;
            c1_prev_reg <= 1'b1;
        end
        else
        begin
            phase_reg <= mc_end ? 4'h0 : phase_reg + 4'h1;
            if (s5p2)
            begin
                samp0_reg <= pins.count_input_zero;
                samp1_reg <= pins.count_input_one;
            end
            c1_prev_reg <= pins.count_input_one;
        end
    end

    // overflow carried from the count phase to S5P1
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pend0_reg <= 1'b0;
            pend1_reg <= 1'b0;
        end
        else
        begin
            pend0_reg <= (ovf_low & ~casc) | (pend0_reg & ~s5p1);
            pend1_reg <= ovf_high | (pend1_reg & ~s5p1);
        end
    end

    // watchdog reset sequencing
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wd_arm_reg <= 1'b0;
            wd_cnt_reg <= 3'h0;
            core_reset <= 1'b0;
        end
        else
        begin
            // reset starts with the next machine cycle
            wd_arm_reg <= wd_trig | (wd_arm_reg & ~mc_end);
            wd_cnt_reg <= wd_cnt_next;
            core_reset <= wd_cnt_next != 3'h0;
        end
    end

    // power state and wake pulses
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pwr_reg <= PWR_RUN;
            hw_pd_reg <= 1'b0;
            rise_seen_reg <= 1'b0;
            wake_res_reg <= 1'b0;
            wake_srv_reg <= 1'b0;
        end
        else if (wd_start)
        begin
            pwr_reg <= PWR_RUN;
            hw_pd_reg <= 1'b0;
            rise_seen_reg <= 1'b0;
            wake_res_reg <= 1'b0;
            wake_srv_reg <= 1'b0;
        end
        else
        begin
            pwr_reg <= pwr_next;
            hw_pd_reg <= hw_pd_next;
            rise_seen_reg <= pd_on & ~exit_now & rise_got;
            // resume after entry or run the handler
            // a pure pin exit carries no interrupt, so it just resumes
            wake_res_reg <= exit_now & (recover_power_select | (pd_on & ~sw_pd));
            wake_srv_reg <= exit_now & ~recover_power_select & ~(pd_on & ~sw_pd);
        end
    end

    // apb read capture at setup
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= (pwrite | ~mapped) ? 32'h00000000 : rd_val;
            err_reg <= ~mapped;
        end
    end

    // =====================================================
    // outputs
    assign cpu_halt = pwr_reg != PWR_RUN;
    assign osc_stop = pd_on;
    assign wake_resume_next = wake_res_reg;
    assign wake_service = wake_srv_reg;
    assign low_timer_overflow_flag = tcon_reg[`CTWP_TC_TF0];
    assign high_timer_overflow_flag = tcon_reg[`CTWP_TC_TF1];

endmodule

// ### inc/ctwp_regs.svh
// register map, field positions and timing counts of the cascaded timer block
`ifndef CTWP_REGS_SVH
`define CTWP_REGS_SVH

// =====================================================
// register offsets (byte addresses)
`define CTWP_IO_CONTROL_REGISTER_OFS 8'h00
`define CTWP_POWER_CONTROL_REGISTER_OFS 8'h04
`define CTWP_TIMER_MODE_REGISTER_OFS 8'h08
`define CTWP_TCON_OFS 8'h0C
`define CTWP_TLOW_OFS 8'h10
`define CTWP_THIGH_OFS 8'h14
`define CTWP_SER_OFS 8'h18
`define CTWP_STAT_OFS 8'h1C

// =====================================================
// io control register fields
`define CTWP_IO_WDOG 7
`define CTWP_IO_CASC 6
`define CTWP_IO_SERIAL_ERROR_FLAG 5
// power control register fields
`define CTWP_PC_HPD 6
`define CTWP_PC_RPD 5
`define CTWP_PC_RSVD 4
`define CTWP_PC_PD 1
`define CTWP_PC_IDL 0
// timer mode register fields
`define CTWP_TM_CT0 2
`define CTWP_TM_CT1 6
// timer control register fields
`define CTWP_TC_TF1 7
`define CTWP_TC_TR1 6
`define CTWP_TC_TF0 5
`define CTWP_TC_TR0 4

// =====================================================
// reset values
`define CTWP_REG8_RST 8'h00

// =====================================================
// machine cycle timing, oscillator clocks per cycle
`define CTWP_MC_CLOCKS 4'hC
`define CTWP_PH_S3P1 4'h4
`define CTWP_PH_S5P1 4'h8
`define CTWP_PH_S5P2 4'h9
`define CTWP_PH_LAST 4'hB
`define CTWP_WD_CYCLES 3'h5

`endif

// ### inc/ctwp_pkg.sv
// types shared by the cascaded timer block and its bench
package ctwp_pkg;

    // external pins, all taken as synchronous
    typedef struct packed {
        logic count_input_zero;
        logic count_input_one;
        logic ext_int0_n;
        logic ext_int1_n;
    } ctwp_pins_t;

    // receiver events at mid stop bit
    typedef struct packed {
        logic stop_sample;
        logic stop_level;
    } ctwp_rx_t;

    // power state, one-hot
    typedef enum logic [2:0] {
        PWR_RUN = 3'h1,
        PWR_IDLE = 3'h2,
        PWR_DOWN = 3'h4
    } ctwp_pwr_t;

endpackage

// ### sim/ctwp_chk.sv
// port assertions for the cascaded timer block
`timescale 1ns/1ps
module ctwp_chk
    import ctwp_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched ports
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_irq,
    input wire logic core_reset,
    input wire logic cpu_halt,
    input wire logic osc_stop,
    input wire logic wake_resume_next,
    input wire logic wake_service,
    input wire logic low_timer_overflow_flag,
    input wire logic high_timer_overflow_flag
);
    logic [6:0] rst_len_reg;
    wire logic woke;
    assign woke = wake_service | wake_resume_next;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // =====================================================
    // watchdog reset length; a counter, since 60 is too long to unroll
    always_ff @(posedge clock)
    begin
        if (!rst_n || !core_reset)
            rst_len_reg <= 7'h00;
        else
            rst_len_reg <= rst_len_reg + 7'h01;
    end
    sequence was_halted;
        $past(cpu_halt) || $past(cpu_halt, 2);
    endsequence
    sequence runs_again;
        !cpu_halt;
    endsequence
    // =====================================================
    // assertions
    a_apb_ready: assert property (pready == penable && (penable || !pslverr))
        else $error("ready or error outside access phase");
    a_wdog_cause: assert property ($rose(core_reset) |-> $past(high_timer_overflow_flag))
        else $error("watchdog reset without high overflow flag");
    a_wdog_len: assert property ($fell(core_reset) |-> rst_len_reg == 7'h3C)
        else $error("watchdog reset not five machine cycles");
    a_wdog_max: assert property (rst_len_reg <= 7'h3C)
        else $error("watchdog reset too long");
    a_wdog_clears: assert property (core_reset && $past(core_reset) |-> !high_timer_overflow_flag && !low_timer_overflow_flag && !cpu_halt)
        else $error("state left over during watchdog reset");
    a_halt_in_down: assert property (osc_stop |-> cpu_halt)
        else $error("oscillator stopped while core runs");
    a_wake_single: assert property (woke |-> !(wake_service && wake_resume_next) ##1 !woke)
        else $error("wake pulse wrong");
    a_wake_exit: assert property (woke |-> was_halted ##0 runs_again)
        else $error("wake pulse without low-power exit");
    a_idle_exit: assert property (cpu_halt && !osc_stop && core_irq |-> ##[1:2] !cpu_halt)
        else $error("idle not left on interrupt");
endmodule
bind ctwp_top ctwp_chk u_ctwp_chk (
    .clock(clock),
    .rst_n(rst_n),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .core_irq(core_irq),
    .core_reset(core_reset),
    .cpu_halt(cpu_halt),
    .osc_stop(osc_stop),
    .wake_resume_next(wake_resume_next),
    .wake_service(wake_service),
    .low_timer_overflow_flag(low_timer_overflow_flag),
    .high_timer_overflow_flag(high_timer_overflow_flag)
);

// ### sim/ctwp_ext_src.sv
// external count source on a count input pin
`timescale 1ns/1ps
module ctwp_ext_src
    import ctwp_pkg::*;
#(
    parameter int HALF = 12
)
(
    // clock
    input wire logic clock,
    // control
    input wire logic run,
    // pin
    output logic cnt_pin
);
    int ph = 0;
    initial cnt_pin = 1'b1;
    always @(posedge clock)
    begin
        ph <= (!run || ph == HALF - 1) ? 0 : ph + 1;
        if (!run)
            cnt_pin <= 1'b1;
        else if (ph == HALF - 1)
            cnt_pin <= ~cnt_pin;
    end
endmodule

// ### sim/ctwp_top_bench.sv
// self-checking bench for the cascaded timer block
`timescale 1ns/1ps
`include "ctwp_regs.svh"
module ctwp_top_bench
    import ctwp_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, d;
    logic pready, pslverr, err, core_reset, cpu_halt, osc_stop, resume, service, flag_lo, flag_hi, src_pin;
    logic cin1 = 1'b1;
    logic int0_n = 1'b1;
    logic int1_n = 1'b1;
    logic core_irq = 1'b0;
    logic src_run = 1'b0;
    ctwp_rx_t rx = 2'h0;
    ctwp_pins_t pins;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int k;
    int n;
    assign pins = '{src_pin, cin1, int0_n, int1_n};
    always #2 clock = ~clock;
    ctwp_top u_ctwp_top (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
        .rx(rx), .core_irq(core_irq), .core_reset(core_reset), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
        .wake_resume_next(resume), .wake_service(service), .low_timer_overflow_flag(flag_lo),
        .high_timer_overflow_flag(flag_hi));
    ctwp_ext_src u_ctwp_ext_src (.clock(clock), .run(src_run), .cnt_pin(src_pin));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
            @(posedge clock);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic sig(input int w);
        case (w)
            0: return flag_hi;
            1: return core_reset;
            2: return osc_stop;
            3: return !osc_stop;
            default: return service | resume;
        endcase
    endfunction
    // bounded wait; n reaches lim when the event never came
    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (sig(w) !== 1'b1 && n < lim)
        begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, n < lim}, 32'h1, "event in time");
    endtask
    initial
    begin
        void'($urandom(52890));
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 0; a < 40; a += 4)
        begin
            apb(0, 8'(a), 32'h0);
            chk({rd[30:0], err}, {30'h0, a == 28, a > 31}, "reset value or unmapped");
        end
        apb(1, 8'h02, 32'hFF);
        chk({31'h0, err}, 32'h1, "misaligned");
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h10);
        apb(0, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h0);
        chk(rd, 32'h0, "reserved power bit");
        d = $urandom();
        apb(1, `CTWP_THIGH_OFS, d);
        apb(0, `CTWP_THIGH_OFS, 32'h0);
        chk(rd, {16'h0, d[15:0]}, "high half");
        apb(1, `CTWP_TCON_OFS, 32'h10);
        apb(0, `CTWP_TLOW_OFS, 32'h0);
        d = rd;
        repeat (48) @(posedge clock);
        apb(0, `CTWP_TLOW_OFS, 32'h0);
        chk({31'h0, rd != d}, 32'h1, "run bit counts");
        apb(1, `CTWP_TCON_OFS, 32'h0);
        $display("test registers ended");
        for (int wd = 0; wd < 2; wd++)
        begin
            k = $urandom_range(7);
            apb(1, `CTWP_THIGH_OFS, 32'hFFFF);
            apb(1, `CTWP_TLOW_OFS, 32'(32'hFFFF - k));
            apb(1, `CTWP_IO_CONTROL_REGISTER_OFS, wd ? 32'hC0 : 32'h40);
            wait_for(0, 12 * k + 40);
            chk({31'h0, n >= 12 * k && n <= 12 * k + 24}, 32'h1, "cascade wrap time");
            chk({31'h0, flag_lo}, 32'h0, "low flag quiet");
            if (wd)
            begin
                wait_for(1, 8);
                n = 0;
                while (core_reset === 1'b1 && n < 100)
                begin
                    @(posedge clock);
                    n++;
                end
                chk(32'(n), 32'h3C, "watchdog reset length");
                apb(0, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
                chk(rd, 32'h0, "io cleared");
                apb(0, `CTWP_TCON_OFS, 32'h0);
                chk(rd, 32'h0, "timer control cleared");
            end
            else
            begin
                apb(0, `CTWP_THIGH_OFS, 32'h0);
                chk(rd, 32'h0, "high half wrapped");
                apb(0, `CTWP_TCON_OFS, 32'h0);
                chk(rd & 32'hA0, 32'h80, "high flag only");
                apb(1, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
                apb(0, `CTWP_TLOW_OFS, 32'h0);
                d = rd;
                repeat (30) @(posedge clock);
                apb(0, `CTWP_TLOW_OFS, 32'h0);
                chk(rd, d, "stopped");
                apb(1, `CTWP_TCON_OFS, 32'h0);
            end
        end
        $display("test cascade and watchdog ended");
        apb(1, `CTWP_TIMER_MODE_REGISTER_OFS, 32'h04);
        apb(1, `CTWP_THIGH_OFS, 32'hFFFF);
        apb(1, `CTWP_TLOW_OFS, 32'hFFFE);
        apb(1, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h40);
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h02);
        wait_for(2, 6);
        src_run <= 1'b1;
        wait_for(3, 200);
        chk({30'h0, flag_hi, flag_lo}, 32'h2, "external count overflow");
        src_run <= 1'b0;
        apb(1, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
        apb(1, `CTWP_TCON_OFS, 32'h0);
        $display("test external count ended");
        for (int m = 0; m < 4; m++)
        begin
            apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, {26'h0, m[0], 3'h0, ~m[1], m[1]});
            repeat (3) @(posedge clock);
            chk({30'h0, cpu_halt, osc_stop}, {30'h0, 1'b1, ~m[1]}, "low power entered");
            if (m[1])
                core_irq <= 1'b1;
            else if (m[0])
                int1_n <= 1'b0;
            else
                int0_n <= 1'b0;
            wait_for(4, 8);
            chk({30'h0, resume, service}, {30'h0, m[0], ~m[0]}, "resume or handler");
            core_irq <= 1'b0;
            int0_n <= 1'b1;
            int1_n <= 1'b1;
            apb(0, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h0);
            chk(rd, m[0] ? 32'h20 : 32'h0, "mode bits cleared");
        end
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h40);
        cin1 <= 1'b0;
        wait_for(2, 6);
        repeat (20) @(posedge clock);
        chk({31'h0, osc_stop}, 32'h1, "held while pin low");
        cin1 <= 1'b1;
        wait_for(4, 8);
        chk({31'h0, resume}, 32'h1, "pin rise leaves");
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h0);
        cin1 <= 1'b0;
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h42);
        wait_for(2, 6);
        int0_n <= 1'b0;
        repeat (30) @(posedge clock);
        chk({31'h0, osc_stop}, 32'h1, "interrupt alone not enough");
        cin1 <= 1'b1;
        wait_for(3, 8);
        int0_n <= 1'b1;
        apb(1, `CTWP_POWER_CONTROL_REGISTER_OFS, 32'h0);
        $display("test power ended");
        for (int s = 0; s < 3; s++)
        begin
            @(posedge clock);
            rx <= '{1'b1, s != 2};
            // pass 1 lands a second stop while the first is unread, giving an overrun
            @(posedge clock);
            rx <= '{s == 1, s != 2};
            @(posedge clock);
            rx <= 2'h0;
            apb(0, `CTWP_SER_OFS, 32'h0);
            chk(rd, 32'h1, "receive done");
            apb(0, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
            chk(rd, s ? 32'h20 : 32'h0, "serial error");
            apb(1, `CTWP_SER_OFS, 32'h0);
            apb(1, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
        end
        apb(0, `CTWP_IO_CONTROL_REGISTER_OFS, 32'h0);
        chk(rd, 32'h0, "error cleared by software");
        $display("test serial ended");
        conclude();
    end
endmodule
